// File: inc/ats_defs.svh
// register offsets, field positions and reset values for the trigger select block
`ifndef ATS_DEFS_SVH
`define ATS_DEFS_SVH
`define ATS_TRIG_SEL_OFFSET 4'h0
`define ATS_START_CTRL_OFFSET 4'h4
`define ATS_SEL_WIDTH 2
`define ATS_SEL_RESET 8'h00
`define ATS_RSVD_HI 7
`define ATS_RSVD_LO 6
`define ATS_NUM_CONV 3
`define ATS_AXI_OKAY 2'h0
`define ATS_AXI_SLVERR 2'h2
`endif

// File: inc/ats_pkg.sv
// types for the trigger select block
package ats_pkg;
    typedef enum logic [1:0] {
        ATS_SRC_PIN_OR_GEN,
        ATS_SRC_PIN_ONLY,
        ATS_SRC_GEN_ONLY,
        ATS_SRC_MOTOR_ONLY
    } ats_src_t;
endpackage

// File: core/ats_trigger_select.sv
// converter trigger source selection with start bits and AXI4-Lite register access
//
// The AXI4-Lite interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`include "ats_defs.svh"

// Behaviour
// - bits 7 and 6 reserved, reset 0, always read 0, writes ignored
// - bits 5:4 select trigger sources for converter 2, reset 00
// - bits 3:2 select trigger sources for converter 1, reset 00
// - bits 1:0 select trigger sources for converter 0, reset 00
// - value 00 enables external pin and general timer starts
// - value 01 enables only external pin starts
// - value 10 general timer only; 11 motor timer only
// - enabled timer request sets start bit like a software write of 1
// - enabled pin falling edge sets start bit
module ats_trigger_select #(
    parameter int NUM_CONV = `ATS_NUM_CONV
) (
    input wire logic mclk, // system clock
    input wire logic rst_n, // async reset, active low
    input wire logic [31:0] s_axi_awaddr, // write address
    input wire logic s_axi_awvalid, // write address valid
    output logic s_axi_awready, // write address ready
    input wire logic [31:0] s_axi_wdata, // write data
    input wire logic [3:0] s_axi_wstrb, // write strobes
    input wire logic s_axi_wvalid, // write data valid
    output logic s_axi_wready, // write data ready
    output logic [1:0] s_axi_bresp, // write response
    output logic s_axi_bvalid, // write response valid
    input wire logic s_axi_bready, // write response ready
    input wire logic [31:0] s_axi_araddr, // read address
    input wire logic s_axi_arvalid, // read address valid
    output logic s_axi_arready, // read address ready
    output logic [31:0] s_axi_rdata, // read data
    output logic [1:0] s_axi_rresp, // read response
    output logic s_axi_rvalid, // read valid
    input wire logic s_axi_rready, // read ready
    input wire logic external_start_pin_n, // external trigger pin, active low
    input wire logic [NUM_CONV-1:0] genTimerReq, // general timer requests, one-cycle pulses
    input wire logic [NUM_CONV-1:0] motorTimerReq, // motor timer requests, one-cycle pulses
    input wire logic [NUM_CONV-1:0] convDone, // converter finished, clears start bit
    output logic [NUM_CONV-1:0] conversion_start_bit // start bits to the converters
);
    // elaboration check: the register has room for exactly three fields
    if (NUM_CONV != `ATS_NUM_CONV) begin : g_bad_conv
        $error("trigger register holds exactly three fields");
    end

    // per-converter source enables
    function automatic logic [2:0] srcEnable(input logic [1:0] sel);
        // bit0 pin, bit1 general timer, bit2 motor timer
        unique case (ats_pkg::ats_src_t'(sel))
            ats_pkg::ATS_SRC_PIN_OR_GEN: srcEnable = 3'h3;
            ats_pkg::ATS_SRC_PIN_ONLY: srcEnable = 3'h1;
            ats_pkg::ATS_SRC_GEN_ONLY: srcEnable = 3'h2;
            ats_pkg::ATS_SRC_MOTOR_ONLY: srcEnable = 3'h4;
        endcase
    endfunction

    logic [5:0] trigSel;
    logic pinSync1, pinSync2, pinPrev;
    logic awPend, wPend;
    logic [31:0] awAddr, wData;
    logic [3:0] wStrb;

    // pin synchroniser and edge history
    // flops reset to the idle high level, so leaving reset makes no false edge
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pinSync1 <= 1'b1;
            pinSync2 <= 1'b1;
            pinPrev <= 1'b1;
        end else begin
            pinSync1 <= external_start_pin_n;
            pinSync2 <= pinSync1;
            pinPrev <= pinSync2;
        end
    end
    wire pinFall = pinPrev & ~pinSync2;

    // write channel capture, either order
    wire doWrite = awPend && wPend && !s_axi_bvalid;
    assign s_axi_awready = !awPend;
    assign s_axi_wready = !wPend;
    wire wrSel = awAddr[3:0] == `ATS_TRIG_SEL_OFFSET && awAddr[31:4] == 28'h0000000;
    wire wrStart = awAddr[3:0] == `ATS_START_CTRL_OFFSET && awAddr[31:4] == 28'h0000000;
    wire selWr = doWrite && wrSel && wStrb[0];
    wire startWr = doWrite && wrStart && wStrb[0];

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            awPend <= 1'b0;
            wPend <= 1'b0;
            awAddr <= 32'h00000000;
            wData <= 32'h00000000;
            wStrb <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `ATS_AXI_OKAY;
        end else begin
            if (s_axi_awvalid && !awPend) begin
                awPend <= 1'b1;
                awAddr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && !wPend) begin
                wPend <= 1'b1;
                wData <= s_axi_wdata;
                wStrb <= s_axi_wstrb;
            end
            if (doWrite) begin
                awPend <= 1'b0;
                wPend <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (wrSel || wrStart) ? `ATS_AXI_OKAY : `ATS_AXI_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // select fields; reserved bits never stored
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            trigSel <= 6'h00;
        end else if (selWr) begin
            trigSel <= wData[5:0];
        end
    end

    // start bits: triggers set, software writes, done clears; a set wins
    logic [NUM_CONV-1:0] next_start, trigHit;
    // a trigger in the same cycle as a clear must not be lost, so it is applied last
    always_comb begin
        logic [2:0] en;
        en = 3'h0;
        next_start = conversion_start_bit;
        for (int i = 0; i < NUM_CONV; i++) begin
            en = srcEnable(trigSel[2*i +: 2]);
            trigHit[i] = (en[0] & pinFall) | (en[1] & genTimerReq[i]) | (en[2] & motorTimerReq[i]);
            if (convDone[i]) next_start[i] = 1'b0;
            if (startWr) next_start[i] = wData[i];
            if (trigHit[i]) next_start[i] = 1'b1;
        end
    end
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) conversion_start_bit <= '0;
        else conversion_start_bit <= next_start;
    end

    // read channel, one-cycle answer
    wire rdSel = s_axi_araddr[3:0] == `ATS_TRIG_SEL_OFFSET && s_axi_araddr[31:4] == 28'h0000000;
    wire rdStart = s_axi_araddr[3:0] == `ATS_START_CTRL_OFFSET && s_axi_araddr[31:4] == 28'h0000000;
    assign s_axi_arready = !s_axi_rvalid;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `ATS_AXI_OKAY;
        end else if (s_axi_arvalid && !s_axi_rvalid) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rdSel ? {26'h0, trigSel} :
                           rdStart ? {29'h0, conversion_start_bit} : 32'h00000000;
            s_axi_rresp <= (rdSel || rdStart) ? `ATS_AXI_OKAY : `ATS_AXI_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // checks
    a_rsvd_zero: assert property (@(posedge mclk) disable iff (!rst_n)
        s_axi_rvalid && s_axi_rresp == `ATS_AXI_OKAY |-> s_axi_rdata[7:6] == 2'h0)
        else $error("reserved bits read nonzero");
    a_field2_write: assert property (@(posedge mclk) disable iff (!rst_n)
        selWr |=> trigSel[5:4] == $past(wData[5:4]))
        else $error("field 2 not stored");
    a_field2_hold: assert property (@(posedge mclk) disable iff (!rst_n)
        !selWr |=> $stable(trigSel[5:4]))
        else $error("field 2 changed without write");
    a_field1_write: assert property (@(posedge mclk) disable iff (!rst_n)
        selWr |=> trigSel[3:2] == $past(wData[3:2]))
        else $error("field 1 not stored");
    a_field1_hold: assert property (@(posedge mclk) disable iff (!rst_n)
        !selWr |=> $stable(trigSel[3:2]))
        else $error("field 1 changed without write");
    a_field0_write: assert property (@(posedge mclk) disable iff (!rst_n)
        selWr |=> trigSel[1:0] == $past(wData[1:0]))
        else $error("field 0 not stored");
    a_field0_hold: assert property (@(posedge mclk) disable iff (!rst_n)
        !selWr |=> $stable(trigSel[1:0]))
        else $error("field 0 changed without write");
    a_pin_mode00: assert property (@(posedge mclk) disable iff (!rst_n)
        trigSel[1:0] == 2'h0 && pinFall |=> conversion_start_bit[0])
        else $error("pin start lost in mode 00");
    a_gen_mode00: assert property (@(posedge mclk) disable iff (!rst_n)
        trigSel[1:0] == 2'h0 && genTimerReq[0] |=> conversion_start_bit[0])
        else $error("general timer start lost in mode 00");
    a_motor_blocked00: assert property (@(posedge mclk) disable iff (!rst_n)
        trigSel[1:0] == 2'h0 && motorTimerReq[0] && !genTimerReq[0] && !pinFall && !startWr
        && !conversion_start_bit[0] |=> !conversion_start_bit[0])
        else $error("motor timer accepted in mode 00");
    a_gen_blocked01: assert property (@(posedge mclk) disable iff (!rst_n)
        trigSel[1:0] == 2'h1 && genTimerReq[0] && !pinFall && !startWr && !conversion_start_bit[0]
        |=> !conversion_start_bit[0])
        else $error("general timer accepted in mode 01");
    a_pin_mode01: assert property (@(posedge mclk) disable iff (!rst_n)
        trigSel[1:0] == 2'h1 && pinFall |=> conversion_start_bit[0])
        else $error("pin start lost in mode 01");
    a_motor_mode11: assert property (@(posedge mclk) disable iff (!rst_n)
        trigSel[3:2] == 2'h3 && motorTimerReq[1] |=> conversion_start_bit[1])
        else $error("motor timer start lost");
    a_gen_blocked11: assert property (@(posedge mclk) disable iff (!rst_n)
        trigSel[3:2] == 2'h3 && genTimerReq[1] && !motorTimerReq[1] && !pinFall && !startWr
        && !conversion_start_bit[1] |=> !conversion_start_bit[1])
        else $error("general timer accepted in mode 11");
    a_pin_blocked10: assert property (@(posedge mclk) disable iff (!rst_n)
        trigSel[5:4] == 2'h2 && pinFall && !genTimerReq[2] && !motorTimerReq[2] && !startWr
        && !conversion_start_bit[2] |=> !conversion_start_bit[2])
        else $error("pin accepted in mode 10");
    a_gen_mode10: assert property (@(posedge mclk) disable iff (!rst_n)
        trigSel[5:4] == 2'h2 && genTimerReq[2] |=> conversion_start_bit[2])
        else $error("general timer start lost");
    a_start_write: assert property (@(posedge mclk) disable iff (!rst_n)
        startWr && !trigHit[0] |=> conversion_start_bit[0] == $past(wData[0]))
        else $error("software start write not applied");
    a_pin_edge: assert property (@(posedge mclk) disable iff (!rst_n)
        $fell(pinSync2) && trigSel[3:2] == 2'h1 |=> conversion_start_bit[1])
        else $error("pin edge did not set start");
    a_disabled_src: assert property (@(posedge mclk) disable iff (!rst_n)
        !trigHit[2] && !startWr && !convDone[2] |=> $stable(conversion_start_bit[2]))
        else $error("start bit changed by disabled source");
endmodule

// File: test/ats_timer_model.sv
// timer units and trigger pin model for the trigger select block
`timescale 1ns/1ps
module ats_timer_model #(
    parameter int N = 3
) (
    input wire logic mclk, // system clock
    output logic [N-1:0] genReq, // general timer pulses
    output logic [N-1:0] motorReq, // motor timer pulses
    output logic [N-1:0] doneReq, // converter done pulses
    output logic pinN // trigger pin, idles high
);
    // idle levels from time zero
    initial begin
        {genReq, motorReq, doneReq} = '0;
        pinN = 1'b1;
    end
    // one-cycle request pulse; kind 3 pulls the pin low for six cycles
    task automatic fire(input int kind, input logic [N-1:0] m);
        begin
            if (kind == 0) genReq <= m;
            if (kind == 1) motorReq <= m;
            if (kind == 2) doneReq <= m;
            if (kind == 3) pinN <= 1'b0;
            @(posedge mclk);
            {genReq, motorReq, doneReq} <= '0;
            if (kind == 3) begin
                repeat (5) @(posedge mclk);
                pinN <= 1'b1;
            end
        end
    endtask
endmodule

// File: test/adc_trigger_source_select_test.sv
// self-checking bench for the trigger select block
`timescale 1ns/1ps
`include "ats_defs.svh"
`define CHK(nm, e, s) begin compares++; if ((e) !== (s)) begin n_errors++; \
    $display("wrong value %s exp %h got %h", nm, e, s); end end
module adc_trigger_source_select_test;
    localparam logic [31:0] SEL = 32'(`ATS_TRIG_SEL_OFFSET);
    localparam logic [31:0] CTL = 32'(`ATS_START_CTRL_OFFSET);
    logic mclk, rst_n, awValid, wValid, bReady, arValid, rReady, awReady, wReady, bValid, rValid, pinN;
    logic arReady;
    logic [3:0] wStrb;
    logic [31:0] awAddr, wData, arAddr, rData, v;
    logic [1:0] bResp, rResp, bExp;
    logic [2:0] genReq, motorReq, doneReq, startBit, e;
    logic [33:0] rq[$], rExp;
    logic [1:0] bq[$];
    int n_errors = 0;
    int compares = 0;
    int f[3];
    ats_trigger_select dut (.mclk(mclk), .rst_n(rst_n), .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid),
        .s_axi_awready(awReady), .s_axi_wdata(wData), .s_axi_wstrb(wStrb), .s_axi_wvalid(wValid),
        .s_axi_wready(wReady), .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
        .s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady), .s_axi_rdata(rData),
        .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady), .external_start_pin_n(pinN),
        .genTimerReq(genReq), .motorTimerReq(motorReq), .convDone(doneReq), .conversion_start_bit(startBit));
    ats_timer_model partner (.mclk(mclk), .genReq(genReq), .motorReq(motorReq), .doneReq(doneReq), .pinN(pinN));
    // clock
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    // answers compared with the oldest note
    always @(posedge mclk) begin
        if (rValid && rReady && rq.size() > 0) begin
            rExp = rq.pop_front();
            `CHK("read", rExp, {rResp, rData})
            if (arAddr == CTL) `CHK("start", rExp[2:0], startBit)
        end
        if (bValid && bReady && bq.size() > 0) begin
            bExp = bq.pop_front();
            `CHK("bresp", bExp, bResp)
        end
    end
    // one write, both channels offered together
    task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] r);
        begin
            bq.push_back(r);
            {awAddr, wData, awValid, wValid, bReady} <= {a, d, 3'b111};
            do begin
                @(posedge mclk);
                if (awReady) awValid <= 1'b0;
                if (wReady) wValid <= 1'b0;
            end while ((awValid && !awReady) || (wValid && !wReady));
            while (!bValid) @(posedge mclk);
            bReady <= 1'b0;
            @(posedge mclk);
        end
    endtask
    // one read, noting response and data; address released once taken
    task automatic rd(input logic [31:0] a, input logic [33:0] x);
        begin
            rq.push_back(x);
            {arAddr, arValid, rReady} <= {a, 2'b11};
            do @(posedge mclk); while (!arReady);
            arValid <= 1'b0;
            while (!rValid) @(posedge mclk);
            rReady <= 1'b0;
            @(posedge mclk);
        end
    endtask
    task automatic wrap_up();
        if (n_errors == 0 && compares > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // watchdog
    initial begin
        #200000;
        n_errors++;
        wrap_up();
    end
    // main sequence
    initial begin
        {awValid, wValid, bReady, arValid, rReady, rst_n} = '0;
        {awAddr, wData, arAddr} = '0;
        wStrb = 4'hF;
        repeat (20) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        v = $urandom(72743) | 32'hC1;
        rd(SEL, 34'h0);
        wr(SEL, v, `ATS_AXI_OKAY);
        rd(SEL, {2'h0, v & 32'h3F});
        // write with the low strobe off must leave the fields alone
        wStrb <= 4'h0;
        wr(SEL, 32'h0, `ATS_AXI_OKAY);
        wStrb <= 4'hF;
        rd(SEL, {2'h0, v & 32'h3F});
        wr(32'h8, v, `ATS_AXI_SLVERR);
        rd(32'h8, {`ATS_AXI_SLVERR, 32'h0});
        for (int i = 0; i < 4; i++) begin
            for (int k = 0; k < 3; k++) f[k] = (i + k) % 4;
            wr(CTL, 32'h0, `ATS_AXI_OKAY);
            v = 32'(f[2] * 16 + f[1] * 4 + f[0]);
            wr(SEL, v, `ATS_AXI_OKAY);
            rd(SEL, {2'h0, v});
            for (int s = 0; s < 3; s++) begin
                for (int k = 0; k < 3; k++) e[k] = (s == 0) ? (f[k] % 2 == 0) : (s == 1) ? (f[k] == 3) : (f[k] < 2);
                partner.fire(s == 2 ? 3 : s, 3'h7);
                repeat (8) @(posedge mclk);
                rd(CTL, {31'h0, e});
                wr(CTL, 32'h0, `ATS_AXI_OKAY);
            end
        end
        wr(SEL, 32'h2A, `ATS_AXI_OKAY);
        wr(CTL, 32'h5, `ATS_AXI_OKAY);
        rd(CTL, {31'h0, 3'h5});
        partner.fire(0, 3'h7);
        @(posedge mclk);
        partner.fire(2, 3'h1);
        repeat (3) @(posedge mclk);
        rd(CTL, {31'h0, 3'h6});
        // mid-run reset clears fields and start bits
        rst_n <= 1'b0;
        repeat (3) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        rd(SEL, 34'h0);
        rd(CTL, 34'h0);
        wrap_up();
    end
endmodule
